// >>> verilog/lsst_pkg.sv
// Shared constants for the linear sensor scan timing ends
package lsst_pkg;
  localparam int unsigned LSST_PIXELS          = 2048;
  localparam int unsigned LSST_INTERVAL_MIN    = 106;
  localparam int unsigned LSST_HIGH_MIN        = 6;
  localparam int unsigned LSST_LOW_MIN         = 100;
  localparam int unsigned LSST_INTEG_EXTRA     = 48;
  localparam int unsigned LSST_FIRST_STROBE    = 89;
  localparam int unsigned LSST_CYCLE_FULL      = 2140;
  localparam int unsigned LSST_CNT_W           = 16;
  localparam int unsigned LSST_PIX_W           = 12;
  localparam int unsigned LSST_VIDEO_W         = 12;
  localparam int unsigned LSST_SYS_CLK_HZ      = 50_000_000;
  localparam int unsigned LSST_LINK_MAX_HZ     = 10_000_000;
  // Sensor clock divider: shortest period, rounded up so rate stays at or under the limit
  localparam int unsigned LSST_CLK_DIV =
    (LSST_SYS_CLK_HZ + LSST_LINK_MAX_HZ - 1) / LSST_LINK_MAX_HZ;
  localparam logic [LSST_CNT_W-1:0] LSST_CNT_ZERO = 16'h0000;
  localparam logic [LSST_CNT_W-1:0] LSST_CNT_ONE  = 16'h0001;
  localparam logic [LSST_PIX_W-1:0] LSST_PIX_ZERO = 12'h000;
  localparam logic [LSST_PIX_W-1:0] LSST_PIX_ONE  = 12'h001;
endpackage : lsst_pkg

// >>> verilog/lsst_if.sv
// Interface joining sensor end and controller end
`timescale 1ns/1ps
interface lsst_if
  import lsst_pkg::*;
();
  logic                    pix_clk_en;
  logic                    scan_launch_pulse;
  logic                    gain_select_pin;
  logic                    sample_strobe;
  logic [LSST_VIDEO_W-1:0] video;
  logic                    scan_finish_flag;

  modport sensor (
    input  pix_clk_en,
    input  scan_launch_pulse,
    input  gain_select_pin,
    output sample_strobe,
    output video,
    output scan_finish_flag
  );
  modport ctrl (
    output pix_clk_en,
    output scan_launch_pulse,
    output gain_select_pin,
    input  sample_strobe,
    input  video,
    input  scan_finish_flag
  );
endinterface : lsst_if

// >>> verilog/lsst_sensor.sv
// Sensor end: integration and pixel shift timing
//
// Behaviour
// - Controller clocks sensor at 10 MHz max.
// - One pixel out per sensor clock.
// - Launch rising edges at least 106 clocks apart.
// - Launch high at least 6 clocks.
// - Launch low at least 100 clocks.
// - Shift starts first clock after launch falls.
// - Integration equals launch high plus 48.
// - First valid pixel on 89th strobe.
// - Controller samples video on strobe rising.
// - Gain pin low high-gain, else low-gain.
// - Full readout needs 2140-clock launch cycle.
// - All pixels integrate over one window.
`timescale 1ns/1ps
module lsst_sensor
  import lsst_pkg::*;
#(
  parameter int unsigned PIXELS = LSST_PIXELS
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Link
  lsst_if.sensor                       link,
  // Light level seen by the pixel under readout
  input  wire logic [LSST_VIDEO_W-1:0] light_level,
  // Status
  output      logic                    integrating,
  output      logic [LSST_PIX_W-1:0]   pixel_index,
  output      logic [LSST_CNT_W-1:0]   integ_time
);

  typedef enum logic [1:0] {LSST_IDLE, LSST_LEAD, LSST_SHIFT} lsst_state_e;

  // Low gain scales the level down; gain pin low means high gain
  localparam int unsigned LOW_GAIN_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // State and counters
  lsst_state_e             state_q, state_d;
  logic                    launch_q;
  logic                    integ_q, integ_d;
  logic [LSST_CNT_W-1:0]   integ_cnt_q, integ_cnt_d;
  logic [LSST_CNT_W-1:0]   tail_q, tail_d;
  logic [LSST_CNT_W-1:0]   lead_q, lead_d;
  logic [LSST_PIX_W-1:0]   pix_q, pix_d;
  logic                    strobe_q, strobe_d;
  logic                    finish_q, finish_d;
  logic [LSST_VIDEO_W-1:0] video_q, video_d;
  logic [LSST_VIDEO_W-1:0] held_q;

  // Decode of the sensor clock and launch level
  wire                    tick       = link.pix_clk_en;
  wire                    fall_seen  = launch_q & ~link.scan_launch_pulse;
  wire                    rise_seen  = ~launch_q & link.scan_launch_pulse;
  wire                    launch_low = ~link.scan_launch_pulse;
  wire                    last_pix   = (pix_q == PIXELS[LSST_PIX_W-1:0] - LSST_PIX_ONE);
  wire                    lead_done  = (lead_q == LSST_FIRST_STROBE[LSST_CNT_W-1:0] - LSST_CNT_ONE);
  wire                    tail_done  = (tail_q == LSST_CNT_ZERO);
  wire [LSST_VIDEO_W-1:0] gained     = link.gain_select_pin ? (light_level >> LOW_GAIN_SHIFT)
                                                            : light_level;

  ////////////////////////////////////////////////////////////////////////////
  // Integration window
  always_comb begin
    integ_d     = integ_q;
    integ_cnt_d = integ_cnt_q;
    tail_d      = tail_q;
    if (tick) begin
      // One global window for every pixel, no rolling shutter
      if (rise_seen) begin
        integ_d     = 1'b1;
        integ_cnt_d = LSST_CNT_ZERO;
      end
      if (integ_q) begin
        integ_cnt_d = integ_cnt_q + LSST_CNT_ONE;
      end
      // Integration runs 48 clocks past the launch fall
      if (fall_seen) begin
        tail_d = LSST_INTEG_EXTRA[LSST_CNT_W-1:0] - LSST_CNT_ONE;
      end else if (integ_q && launch_low) begin
        if (tail_done) begin
          integ_d = 1'b0;
        end else begin
          tail_d = tail_q - LSST_CNT_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout sequencer
  always_comb begin
    state_d  = state_q;
    lead_d   = lead_q;
    pix_d    = pix_q;
    strobe_d = 1'b0;
    finish_d = 1'b0;
    video_d  = video_q;
    if (tick) begin
      // A new fall restarts the readout even mid-line; that line is lost
      if (fall_seen) begin
        state_d  = LSST_LEAD;
        lead_d   = LSST_CNT_ONE;
        strobe_d = 1'b1;
        video_d  = '0;
      end else begin
        case (state_q)
          LSST_IDLE: begin
            strobe_d = 1'b1;
          end
          LSST_LEAD: begin
            strobe_d = 1'b1;
            lead_d   = lead_q + LSST_CNT_ONE;
            if (lead_done) begin
              state_d = LSST_SHIFT;
              pix_d   = LSST_PIX_ZERO;
              video_d = held_q;
            end
          end
          LSST_SHIFT: begin
            strobe_d = 1'b1;
            if (last_pix) begin
              state_d  = LSST_IDLE;
              finish_d = 1'b1;
              video_d  = '0;
            end else begin
              pix_d   = pix_q + LSST_PIX_ONE;
              video_d = held_q;
            end
          end
          default: state_d = LSST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch level is seen on sensor clock edges only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      launch_q <= 1'b0;
    end else if (tick) begin
      launch_q <= link.scan_launch_pulse;
    end
  end

  // Window flag and counters
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      integ_q     <= 1'b0;
      integ_cnt_q <= LSST_CNT_ZERO;
      tail_q      <= LSST_CNT_ZERO;
    end else begin
      integ_q     <= integ_d;
      integ_cnt_q <= integ_cnt_d;
      tail_q      <= tail_d;
    end
  end

  // Sequencer state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= LSST_IDLE;
      lead_q  <= LSST_CNT_ZERO;
      pix_q   <= LSST_PIX_ZERO;
    end else begin
      state_q <= state_d;
      lead_q  <= lead_d;
      pix_q   <= pix_d;
    end
  end

  // Strobe, finish and video from flops; strobe and finish each stand one clean cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      finish_q <= 1'b0;
      video_q  <= '0;
    end else begin
      strobe_q <= strobe_d;
      finish_q <= finish_d;
      video_q  <= video_d;
    end
  end

  // Level sampled every cycle so a gain change lands on the next pixel
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      held_q <= '0;
    end else begin
      held_q <= gained;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link outputs
  assign link.sample_strobe    = strobe_q;
  assign link.video            = video_q;
  assign link.scan_finish_flag = finish_q;

  // Status outputs
  assign integrating           = integ_q;
  assign pixel_index           = pix_q;
  assign integ_time            = integ_cnt_q;

endmodule : lsst_sensor

// >>> verilog/lsst_ctrl.sv
// Controller end: sensor clock, launch pulse and video capture
`timescale 1ns/1ps
module lsst_ctrl
  import lsst_pkg::*;
#(
  parameter int unsigned HIGH_CLKS = LSST_CYCLE_FULL - LSST_LOW_MIN,
  parameter int unsigned LOW_CLKS  = LSST_LOW_MIN
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Link
  lsst_if.ctrl                         link,
  // User control
  input  wire logic                    run,
  input  wire logic                    low_gain,
  // Captured pixels
  output      logic                    pix_valid,
  output      logic [LSST_VIDEO_W-1:0] pix_data,
  output      logic                    line_done
);

  // Clamp to the legal minimums so the sensor is never overdriven
  localparam int unsigned HI = (HIGH_CLKS < LSST_HIGH_MIN) ? LSST_HIGH_MIN : HIGH_CLKS;
  localparam int unsigned LO = (LOW_CLKS < LSST_LOW_MIN) ? LSST_LOW_MIN : LOW_CLKS;
  localparam int unsigned LO2 = (HI + LO < LSST_INTERVAL_MIN) ? LSST_INTERVAL_MIN - HI : LO;
  localparam logic [LSST_CNT_W-1:0] HI_C  = HI[LSST_CNT_W-1:0];
  localparam logic [LSST_CNT_W-1:0] LO_C  = LO2[LSST_CNT_W-1:0];
  localparam logic [3:0]            DIV_C = LSST_CLK_DIV[3:0];

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]              div_q;
  logic                    launch_q;
  logic [LSST_CNT_W-1:0]   phase_q;
  logic                    valid_q, done_q;
  logic [LSST_VIDEO_W-1:0] data_q;
  logic                    seen_first_q;

  wire tick     = (div_q == DIV_C - 4'h1);
  // The finish strobe carries no pixel
  wire take_strobe = link.sample_strobe & ~link.scan_finish_flag;
  wire phase_end = launch_q ? (phase_q == HI_C - LSST_CNT_ONE)
                            : (phase_q == LO_C - LSST_CNT_ONE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_q <= 4'h0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
    end
  end

  // Exposure set by the high time of the launch pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      launch_q <= 1'b0;
      phase_q  <= LSST_CNT_ZERO;
    end else if (tick) begin
      if (phase_end) begin
        launch_q <= ~launch_q & run;
        phase_q  <= LSST_CNT_ZERO;
      end else begin
        phase_q <= phase_q + LSST_CNT_ONE;
      end
    end
  end

  // Skip lead-in strobes; the sensor marks valid data by its own count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      valid_q      <= 1'b0;
      done_q       <= 1'b0;
      data_q       <= '0;
      seen_first_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      done_q  <= link.scan_finish_flag;
      if (link.scan_finish_flag) begin
        seen_first_q <= 1'b0;
      end
      if (link.sample_strobe && link.video != '0) begin
        seen_first_q <= 1'b1;
      end
      if (take_strobe && (seen_first_q || link.video != '0)) begin
        valid_q <= 1'b1;
        data_q  <= link.video;
      end
    end
  end

  assign link.pix_clk_en        = tick;
  assign link.scan_launch_pulse = launch_q;
  assign link.gain_select_pin   = low_gain;
  assign pix_valid              = valid_q;
  assign pix_data               = data_q;
  assign line_done              = done_q;

endmodule : lsst_ctrl

// >>> tb/lsst_link_checker.sv
// Concurrent checks on the link between the two ends
`timescale 1ns/1ps
module lsst_link_checker
  import lsst_pkg::*;
#(
  parameter int unsigned PIXELS = LSST_PIXELS
) (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  // Link
  input wire logic                    pix_clk_en,
  input wire logic                    scan_launch_pulse,
  input wire logic                    gain_select_pin,
  input wire logic                    sample_strobe,
  input wire logic [LSST_VIDEO_W-1:0] video,
  input wire logic                    scan_finish_flag
);
  logic [LSST_CNT_W-1:0] hi_q;
  logic [LSST_CNT_W-1:0] lo_q;
  logic [LSST_CNT_W-1:0] strb_q;
  logic                  launch_q;
  logic [LSST_CNT_W-1:0] per_q;
  logic                  strb_inc;
  int unsigned           lead;
  assign lead = LSST_FIRST_STROBE - 1;
  // Saturated until the first fall so idle strobes after reset do not count
  assign strb_inc = sample_strobe && (strb_q != '1);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Ticks per launch phase; strobes since launch fell
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hi_q     <= LSST_CNT_ZERO;
      lo_q     <= LSST_CNT_ZERO;
      strb_q   <= '1;
      per_q    <= LSST_CNT_W'(LSST_INTERVAL_MIN);
      launch_q <= 1'b0;
    end else begin
      launch_q <= scan_launch_pulse;
      per_q    <= (!launch_q && scan_launch_pulse) ? LSST_CNT_ZERO
                                                   : per_q + LSST_CNT_W'(pix_clk_en);
      hi_q     <= scan_launch_pulse ? hi_q + LSST_CNT_W'(pix_clk_en) : LSST_CNT_ZERO;
      lo_q     <= scan_launch_pulse ? LSST_CNT_ZERO : lo_q + LSST_CNT_W'(pix_clk_en);
      strb_q   <= (launch_q && !scan_launch_pulse) ? LSST_CNT_ZERO
                                                   : strb_q + LSST_CNT_W'(strb_inc);
    end
  end
  property p_clk_rate; pix_clk_en |=> !pix_clk_en [*4]; endproperty
  a_clk_rate: assert property (p_clk_rate) else $error("sensor clock too fast");
  property p_interval; $rose(scan_launch_pulse) |-> per_q >= LSST_INTERVAL_MIN; endproperty
  a_interval: assert property (p_interval) else $error("launch interval short");
  property p_full_line; $fell(scan_launch_pulse) |-> strb_q > lead + PIXELS; endproperty
  a_full_line: assert property (p_full_line) else $error("line cut by launch");
  property p_strobe_space; sample_strobe |=> !sample_strobe [*4]; endproperty
  a_strobe_space: assert property (p_strobe_space) else $error("strobe spacing");
  property p_hi_min; $fell(scan_launch_pulse) |-> hi_q >= LSST_HIGH_MIN; endproperty
  a_hi_min: assert property (p_hi_min) else $error("launch high short");
  property p_lo_min; $rose(scan_launch_pulse) |-> lo_q >= LSST_LOW_MIN; endproperty
  a_lo_min: assert property (p_lo_min) else $error("launch low short");
  property p_fall_strobe; $fell(scan_launch_pulse) |-> ##[1:15] sample_strobe; endproperty
  a_fall_strobe: assert property (p_fall_strobe) else $error("no strobe after fall");
  property p_lead_in; sample_strobe && strb_q < lead |-> video == '0; endproperty
  a_lead_in: assert property (p_lead_in) else $error("video in lead-in");
  property p_pixels;
    sample_strobe && strb_q >= lead && strb_q < lead + PIXELS |-> video != '0 && !scan_finish_flag;
  endproperty
  a_pixels: assert property (p_pixels) else $error("pixel missing");
  property p_finish_pos;
    scan_finish_flag |-> sample_strobe && strb_q == lead + PIXELS && video == '0;
  endproperty
  a_finish_pos: assert property (p_finish_pos) else $error("finish misplaced");
  property p_finish_once; scan_finish_flag |=> !scan_finish_flag [*8]; endproperty
  a_finish_once: assert property (p_finish_once) else $error("finish repeated");
endmodule : lsst_link_checker

// >>> tb/linear_sensor_scan_timing_tb.sv
// Bench joining both ends of the sensor link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module linear_sensor_scan_timing_tb;
  import lsst_pkg::*;
  // Short line and launch keep the run brief
  localparam int unsigned PIX = 8;
  localparam int unsigned HI  = 6;
  logic                    sys_clk, rst_n, run, low_gain, pix_valid, line_done, st_q, meas;
  logic                    integrating;
  logic [LSST_PIX_W-1:0]   pixel_index;
  logic [LSST_VIDEO_W-1:0] light_level, pix_data, exp_pix;
  logic [LSST_CNT_W-1:0]   integ_time;
  int                      failures, check_count, cyc, lines, n_valid, strb, first;
  lsst_if link_if ();
  lsst_sensor #(.PIXELS(PIX)) lsst_sensor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link_if), .light_level(light_level), .integrating(integrating),
    .pixel_index(pixel_index), .integ_time(integ_time));
  lsst_ctrl #(.HIGH_CLKS(HI)) lsst_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link_if), .run(run), .low_gain(low_gain), .pix_valid(pix_valid),
    .pix_data(pix_data), .line_done(line_done));
  lsst_link_checker #(.PIXELS(PIX)) lsst_link_checker_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .pix_clk_en(link_if.pix_clk_en),
    .scan_launch_pulse(link_if.scan_launch_pulse), .gain_select_pin(link_if.gain_select_pin),
    .sample_strobe(link_if.sample_strobe), .video(link_if.video),
    .scan_finish_flag(link_if.scan_finish_flag));
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Strobe count from launch fall; watchdog
  always @(posedge sys_clk) begin
    cyc++;
    st_q <= link_if.scan_launch_pulse;
    if (st_q && !link_if.scan_launch_pulse) strb = 0;
    else if (link_if.sample_strobe) begin
      strb++;
      if (first == 0 && link_if.video !== '0) first = strb;
    end
    if (pix_valid && meas) begin
      n_valid++;
      `CHK("pix_data", exp_pix, pix_data)
    end
    if (line_done) lines++;
    if (cyc == 10000) begin
      failures++;
      finish_test();
    end
  end
  // One line settles the new setting, the next is measured
  task automatic scan_line(input logic g, input logic [LSST_VIDEO_W-1:0] lv, e);
    int l0;
    low_gain = g;
    light_level = lv;
    meas = 1'b0;
    l0 = lines;
    while (lines < l0 + 2) begin
      @(negedge sys_clk);
      if (lines == l0 + 1 && !meas) begin
        meas = 1'b1;
        exp_pix = e;
        n_valid = 0;
        first = 0;
      end
    end
    `CHK("line pixels", PIX, n_valid)
    `CHK("first strobe", LSST_FIRST_STROBE, first)
    `CHK("integ time", LSST_CNT_W'(HI + LSST_INTEG_EXTRA), integ_time)
    `CHK("gain pin", g, link_if.gain_select_pin)
    `CHK("last index", LSST_PIX_W'(PIX - 1), pixel_index)
    `CHK("integrating", 1'b0, integrating)
  endtask : scan_line
  task automatic finish_test();
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    low_gain = 1'b0;
    meas = 1'b0;
    light_level = 12'h123;
    exp_pix = 12'h000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    run = 1'b1;
    scan_line(1'b0, 12'h123, 12'h123);
    scan_line(1'b1, 12'h123, 12'h048);
    scan_line(1'b1, 12'hFFF, 12'h3FF);
    scan_line(1'b0, 12'h001, 12'h001);
    finish_test();
  end
endmodule : linear_sensor_scan_timing_tb
